// ### design/feb_ahb_slave.sv
// AHB-Lite slave front end for the fault event enable bank
`timescale 1ns/1ns
module feb_ahb_slave
    import feb_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        ce_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic      [31:0] hrdata_o,
    output feb_regwr_t       regwr_o,
    output logic      [29:0] rd_idx_o,
    input  wire logic [15:0] rd_data_i
);

    // ****************************************************************
    // Address phase capture
    // ****************************************************************
    feb_bus_state_t state_ff;
    feb_bus_state_t nxt_state;
    logic [29:0]    idx_ff;
    logic           word_ff;
    logic [31:0]    hrdata_ff;

    wire addr_take = hsel_i & htrans_i[1] & hready_i;
    wire is_word   = (hsize_i == SIZE_WORD);

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_RWAIT: nxt_state = ST_RDONE;
            ST_IDLE, ST_WDATA, ST_RDONE: begin
                if (addr_take) begin
                    nxt_state = hwrite_i ? ST_WDATA : ST_RWAIT;
                end else if (hready_i) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_IDLE;
            idx_ff   <= '0;
            word_ff  <= 1'b0;
        end else if (ce_i) begin
            state_ff <= nxt_state;
            if (addr_take) begin
                idx_ff  <= haddr_i[31:2];
                word_ff <= is_word;
            end
        end
    end

    // ****************************************************************
    // Data phase: writes finish at once, reads take one wait state
    // ****************************************************************
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            hrdata_ff <= RD_DEFAULT;
        end else if (ce_i && state_ff == ST_RWAIT) begin
            hrdata_ff <= {16'h0000, rd_data_i};
        end
    end

    assign regwr_o.en   = (state_ff == ST_WDATA) & word_ff & ce_i;
    assign regwr_o.idx  = idx_ff;
    assign regwr_o.data = hwdata_i[15:0];
    assign rd_idx_o     = idx_ff;
    assign hreadyout_o  = (state_ff != ST_RWAIT);
    assign hresp_o      = 1'b0;
    assign hrdata_o     = hrdata_ff;

endmodule : feb_ahb_slave

// ### design/feb_event_bank.sv
// Fault event enable registers, event request and interrupt logic
`timescale 1ns/1ns
module feb_event_bank
    import feb_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        reset_n_i,
    input  wire logic        ce_i,
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic [31:0] hwdata_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic             hresp_o,
    output logic      [31:0] hrdata_o,
    input  feb_fault_t       fault_i,
    output logic             event_req_o,
    output logic      [8:0]  event_src_o,
    output logic             irq_o
);

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    function automatic logic [15:0] keep_writable(
        input logic [15:0] data,
        input logic [15:0] wmask
    );
        keep_writable = data & wmask;
    endfunction : keep_writable

    function automatic logic idx_hit(
        input logic [29:0] idx,
        input logic [29:0] target
    );
        idx_hit = (idx == target);
    endfunction : idx_hit

    // ****************************************************************
    // Bus slave
    // ****************************************************************
    feb_regwr_t  regwr;
    logic [29:0] rd_idx;
    logic [15:0] rd_data;

    feb_ahb_slave u_slave (
        .sys_clk_i   (sys_clk_i),
        .reset_n_i   (reset_n_i),
        .ce_i        (ce_i),
        .hsel_i      (hsel_i),
        .haddr_i     (haddr_i),
        .htrans_i    (htrans_i),
        .hwrite_i    (hwrite_i),
        .hsize_i     (hsize_i),
        .hwdata_i    (hwdata_i),
        .hready_i    (hready_i),
        .hreadyout_o (hreadyout_o),
        .hresp_o     (hresp_o),
        .hrdata_o    (hrdata_o),
        .regwr_o     (regwr),
        .rd_idx_o    (rd_idx),
        .rd_data_i   (rd_data)
    );

    // ****************************************************************
    // Write decode
    // ****************************************************************
    wire wr_ana    = regwr.en & idx_hit(regwr.idx, IDX_ANA);
    wire wr_com    = regwr.en & idx_hit(regwr.idx, IDX_COM);
    wire wr_meas   = regwr.en & idx_hit(regwr.idx, IDX_MEAS);
    wire wr_status = regwr.en & idx_hit(regwr.idx, IDX_STATUS);
    wire wr_mask   = regwr.en & idx_hit(regwr.idx, IDX_MASK);

    // ****************************************************************
    // Enable registers
    // ****************************************************************
    logic [15:0] ana_en_ff;
    logic [15:0] com_en_ff;
    logic [15:0] meas_en_ff;
    logic [15:0] nxt_ana_en;
    logic [15:0] nxt_com_en;
    logic [15:0] nxt_meas_en;

    // Reserved bits are stripped before storage
    assign nxt_ana_en  = keep_writable(regwr.data, ANA_WMASK);
    assign nxt_com_en  = keep_writable(regwr.data, COM_WMASK);
    assign nxt_meas_en = keep_writable(regwr.data, MEAS_WMASK);

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ana_en_ff  <= EN_RESET;
            com_en_ff  <= EN_RESET;
            meas_en_ff <= EN_RESET;
        end else if (ce_i) begin
            if (wr_ana) begin
                ana_en_ff <= nxt_ana_en;
            end
            if (wr_com) begin
                com_en_ff <= nxt_com_en;
            end
            if (wr_meas) begin
                meas_en_ff <= nxt_meas_en;
            end
        end
    end

    // ****************************************************************
    // Enable vector, one bit per fault source
    // ****************************************************************
    feb_fault_t enable;

    assign enable.monitor_selftest   = ana_en_ff[ANA_MONBIST];
    assign enable.balance            = ana_en_ff[ANA_BAL];
    assign enable.framing_error      = com_en_ff[COM_FRAME];
    assign enable.comm_checksum      = com_en_ff[COM_CRC];
    assign enable.error_counter_full = com_en_ff[COM_ERRCNT];
    assign enable.response_length    = com_en_ff[COM_RSPLEN];
    assign enable.primary_cal        = meas_en_ff[MEAS_PRIM];
    assign enable.secondary_cal      = meas_en_ff[MEAS_SEC];
    assign enable.sync_cycle         = meas_en_ff[MEAS_SYNC];

    // ****************************************************************
    // Gated faults and event request
    // ****************************************************************
    logic [8:0] gated;
    logic       event_req_ff;
    logic [8:0] event_src_ff;

    // A disabled fault is masked out before the OR
    assign gated = fault_i & enable;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            event_req_ff <= 1'b0;
            event_src_ff <= EVT_RESET;
        end else if (ce_i) begin
            event_req_ff <= |gated;
            event_src_ff <= gated;
        end
    end

    assign event_req_o = event_req_ff;
    assign event_src_o = event_src_ff;

    // ****************************************************************
    // Sticky status, mask and interrupt
    // ****************************************************************
    logic [8:0] status_ff;
    logic [8:0] mask_ff;
    logic [8:0] w1c;
    logic [8:0] nxt_status;

    assign w1c        = wr_status ? regwr.data[8:0] : EVT_RESET;
    // A new event in the clearing cycle keeps its bit set
    assign nxt_status = (status_ff & ~w1c) | gated;

    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            status_ff <= EVT_RESET;
            mask_ff   <= EVT_RESET;
        end else if (ce_i) begin
            status_ff <= nxt_status;
            if (wr_mask) begin
                mask_ff <= regwr.data[8:0];
            end
        end
    end

    assign irq_o = |(status_ff & mask_ff);

    // ****************************************************************
    // Read mux, unmapped and reserved bits read zero
    // ****************************************************************
    wire rd_ana    = idx_hit(rd_idx, IDX_ANA);
    wire rd_com    = idx_hit(rd_idx, IDX_COM);
    wire rd_meas   = idx_hit(rd_idx, IDX_MEAS);
    wire rd_status = idx_hit(rd_idx, IDX_STATUS);
    wire rd_mask   = idx_hit(rd_idx, IDX_MASK);

    assign rd_data = rd_ana    ? ana_en_ff            :
                     rd_com    ? com_en_ff            :
                     rd_meas   ? meas_en_ff           :
                     rd_status ? {7'h00, status_ff}   :
                     rd_mask   ? {7'h00, mask_ff}     :
                                 EN_RESET;

endmodule : feb_event_bank

// ### pkg/feb_pkg.sv
// Shared constants and types for the fault event enable bank
// How it works
// - Analog bit 1 enables balance fault events
// - Analog bit 0 enables monitor self-test events
// - Comm bit 4 enables response length events
// - Comm bit 2 enables error counter full events
// - Comm bit 1 enables frame checksum events
// - Comm bit 0 enables framing error events
// - Meas bit 2 enables sync cycle events
// - Meas bit 1 enables secondary calibration events
// - Meas bit 0 enables primary calibration events
// - All enable bits reset to zero
// - Unused bits read zero, ignore writes
package feb_pkg;

    // ****************************************************************
    // Register indices, byte address is four times the index
    // ****************************************************************
    localparam int          IDX_W       = 30;
    localparam logic [29:0] IDX_ANA     = 30'h0000_0432;
    localparam logic [29:0] IDX_COM     = 30'h0000_0433;
    localparam logic [29:0] IDX_MEAS    = 30'h0000_0434;
    localparam logic [29:0] IDX_STATUS  = 30'h0000_0435;
    localparam logic [29:0] IDX_MASK    = 30'h0000_0436;

    // ****************************************************************
    // Field positions, writable masks and reset values
    // ****************************************************************
    localparam int          REG_W       = 16;
    localparam int          EVT_N       = 9;
    localparam int          ANA_MONBIST = 0;
    localparam int          ANA_BAL     = 1;
    localparam int          COM_FRAME   = 0;
    localparam int          COM_CRC     = 1;
    localparam int          COM_ERRCNT  = 2;
    localparam int          COM_RSPLEN  = 4;
    localparam int          MEAS_PRIM   = 0;
    localparam int          MEAS_SEC    = 1;
    localparam int          MEAS_SYNC   = 2;
    localparam logic [15:0] ANA_WMASK   = 16'h0003;
    localparam logic [15:0] COM_WMASK   = 16'h0017;
    localparam logic [15:0] MEAS_WMASK  = 16'h0007;
    localparam logic [15:0] EN_RESET    = 16'h0000;
    localparam logic [8:0]  EVT_RESET   = 9'h000;
    localparam logic [31:0] RD_DEFAULT  = 32'h0000_0000;
    localparam logic [2:0]  SIZE_WORD   = 3'h2;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef struct packed {
        logic sync_cycle;
        logic secondary_cal;
        logic primary_cal;
        logic response_length;
        logic error_counter_full;
        logic comm_checksum;
        logic framing_error;
        logic balance;
        logic monitor_selftest;
    } feb_fault_t;

    typedef struct packed {
        logic        en;
        logic [29:0] idx;
        logic [15:0] data;
    } feb_regwr_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'h1,
        ST_WDATA = 4'h2,
        ST_RWAIT = 4'h4,
        ST_RDONE = 4'h8
    } feb_bus_state_t;

endpackage : feb_pkg

// ### verification/feb_event_bank_checker.sv
// Concurrent checks on the fault event enable bank ports
`timescale 1ns/1ns
module feb_event_bank_checker
    import feb_pkg::*;
(
    input logic        sys_clk_i,
    input logic        reset_n_i,
    input logic        ce_i,
    input logic        hsel_i,
    input logic [1:0]  htrans_i,
    input logic        hwrite_i,
    input logic        hready_i,
    input logic        hreadyout_o,
    input logic        hresp_o,
    input logic [31:0] hrdata_o,
    input feb_fault_t  fault_i,
    input logic        event_req_o,
    input logic [8:0]  event_src_o
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    logic taken;
    logic wr_seen_ff;
    assign taken = hsel_i & htrans_i[1] & hready_i & ce_i;
    always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
        if (!reset_n_i)
            wr_seen_ff <= 1'b0;
        else if (taken & hwrite_i)
            wr_seen_ff <= 1'b1;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!reset_n_i);
    AST_RD_WAIT: assert property (taken && !hwrite_i
        |=> !hreadyout_o ##1 hreadyout_o) else $error("read wait wrong");
    AST_WR_NOWAIT: assert property (taken && hwrite_i |=> hreadyout_o)
        else $error("write stalled");
    AST_OKAY: assert property (hresp_o == 1'b0) else $error("bad resp");
    AST_RD_ZERO: assert property (hrdata_o[31:9] == 23'h0)
        else $error("reserved read bits set");
    AST_REQ_OR: assert property (event_req_o == (|event_src_o))
        else $error("request not OR of sources");
    AST_SRC_GATED: assert property ($past(ce_i) |->
        (event_src_o & ~$past(fault_i)) == 9'h0) else $error("spurious src");
    AST_RST_QUIET: assert property (!wr_seen_ff |->
        event_src_o == 9'h0) else $error("event before enable");
    AST_NO_FAULT: assert property (ce_i && fault_i == 9'h0
        |=> !event_req_o) else $error("event without fault");
    COV_RD: cover property (taken && !hwrite_i);
    COV_WR: cover property (taken && hwrite_i);
    COV_EVT: cover property ($rose(event_req_o));
endmodule : feb_event_bank_checker

bind feb_event_bank feb_event_bank_checker feb_event_bank_checker_i (
    .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i),
    .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .hrdata_o(hrdata_o), .fault_i(fault_i), .event_req_o(event_req_o),
    .event_src_o(event_src_o));

// ### verification/tb_top.sv
// Self-checking bench for the fault event enable bank
`timescale 1ns/1ns
module tb_top;
    import feb_pkg::*;
    logic        sys_clk_i = 1'b0;
    logic        reset_n_i = 1'b0;
    logic        hsel_i    = 1'b0;
    logic [31:0] haddr_i   = 32'h0;
    logic [1:0]  htrans_i  = 2'h0;
    logic        hwrite_i  = 1'b0;
    logic [2:0]  hsize_i   = SIZE_WORD;
    logic [31:0] hwdata_i  = 32'h0;
    feb_fault_t  fault_i   = '0;
    logic        hreadyout_o, hresp_o, event_req_o, irq_o;
    logic [31:0] hrdata_o;
    logic [8:0]  event_src_o;
    logic [31:0] rq[$];
    logic [10:0] eq[$];
    logic        ev_due = 1'b0;
    logic        rd_ph  = 1'b0;
    logic        rdy_s  = 1'b1;
    logic [31:0] seed   = 32'h4865;
    logic [31:0] ena, enc, enm, b;
    int          n_errors = 0;
    int          tests_run = 0;
    int          cyc = 0;
    logic [29:0] ix [4] = '{IDX_ANA, IDX_COM, IDX_MEAS, 30'h437};
    logic [15:0] wm [4] = '{16'h0003, 16'h0017, 16'h0007, 16'h0000};
    int          grp [9] = '{0, 0, 1, 1, 1, 1, 2, 2, 2};
    int          bp [9]  = '{0, 1, 0, 1, 2, 4, 0, 1, 2};

    always #5 sys_clk_i = ~sys_clk_i;

    feb_event_bank feb_event_bank_i (
        .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .ce_i(1'b1),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
        .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
        .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o),
        .hresp_o(hresp_o), .hrdata_o(hrdata_o), .fault_i(fault_i),
        .event_req_o(event_req_o), .event_src_o(event_src_o),
        .irq_o(irq_o));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task automatic chk(input string nm, input logic [31:0] e, g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // Ready is taken from the settled value before each edge
    task automatic bus(input logic w, input logic [29:0] idx,
                       input logic [31:0] d);
        hsel_i   <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i  <= {idx, 2'h0};
        hwrite_i <= w;
        do @(posedge sys_clk_i); while (!rdy_s);
        hsel_i   <= 1'b0;
        htrans_i <= 2'h0;
        if (w) hwdata_i <= d;
        do @(posedge sys_clk_i); while (!rdy_s);
    endtask : bus

    task automatic rd(input logic [29:0] idx, input logic [31:0] e);
        rq.push_back(e);
        bus(1'b0, idx, 32'h0);
    endtask : rd

    task automatic set_en(input logic [31:0] a, c, m);
        ena = a;
        enc = c;
        enm = m;
        bus(1'b1, IDX_ANA, a);
        bus(1'b1, IDX_COM, c);
        bus(1'b1, IDX_MEAS, m);
    endtask : set_en

    task automatic flt(input logic [8:0] f, input logic irq);
        logic [8:0] e;
        e = f & {enm[2:0], enc[4], enc[2:0], ena[1:0]};
        fault_i <= f;
        @(posedge sys_clk_i);
        ev_due <= 1'b1;
        eq.push_back({irq, |e, e});
        @(posedge sys_clk_i);
        ev_due <= 1'b0;
    endtask : flt

    task automatic do_reset();
        reset_n_i <= 1'b0;
        {ena, enc, enm} = '0;
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        @(posedge sys_clk_i);
    endtask : do_reset

    // ****************************************************************
    // Output watcher and timeout
    // ****************************************************************
    // Outputs are looked at mid-cycle, where they are settled
    always @(negedge sys_clk_i) begin
        rdy_s = hreadyout_o;
        if (rd_ph && hreadyout_o && rq.size() > 0)
            chk("hrdata", rq.pop_front(), hrdata_o);
        if (rd_ph && hreadyout_o)
            rd_ph = 1'b0;
        if (hsel_i && htrans_i[1] && hreadyout_o && !hwrite_i)
            rd_ph = 1'b1;
        if (ev_due && eq.size() > 0)
            chk("event", {21'h0, eq.pop_front()},
                {21'h0, irq_o, event_req_o, event_src_o});
    end

    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_errors++;
            end_of_test();
        end
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        do_reset();
        flt(9'h1FF, 1'b0);
        foreach (ix[i]) rd(ix[i], 32'h0);
        $display("test reset done");
        foreach (ix[i]) begin
            bus(1'b1, ix[i], 32'hFFFF_FFFF);
            rd(ix[i], {16'h0, wm[i]});
        end
        hsize_i <= 3'h0;
        bus(1'b1, IDX_ANA, 32'h0);
        hsize_i <= SIZE_WORD;
        rd(IDX_ANA, {16'h0, wm[0]});
        $display("test reserved done");
        for (int i = 0; i < 9; i++) begin
            b = 32'h1 << bp[i];
            set_en(grp[i] == 0 ? b : 0, grp[i] == 1 ? b : 0,
                   grp[i] == 2 ? b : 0);
            flt(9'h1FF, 1'b0); // to
        end
        $display("test sources done");
        for (int i = 0; i < 12; i++) begin
            set_en(rnd(), rnd(), rnd());
            flt(9'(rnd()), 1'b0);
        end
        flt(9'h000, 1'b0);
        $display("test random done");
        bus(1'b1, IDX_STATUS, 32'h1FF);
        set_en(32'h2, 32'h0, 32'h0);
        flt(9'h002, 1'b0);
        flt(9'h000, 1'b0);
        rd(IDX_STATUS, 32'h2);
        bus(1'b1, IDX_MASK, 32'h2);
        flt(9'h000, 1'b1);
        bus(1'b1, IDX_STATUS, 32'h2);
        flt(9'h000, 1'b0);
        rd(IDX_STATUS, 32'h0);
        $display("test interrupt done");
        do_reset();
        flt(9'h1FF, 1'b0);
        rd(IDX_COM, 32'h0);
        $display("test second reset done");
        repeat (4) @(posedge sys_clk_i);
        end_of_test();
    end
endmodule : tb_top
